/* File: design/tpo_pixel_output.sv */
// Pixel output stage: maps recovered link channels to even/odd pixel buses and controls.
// How it works
// - In one-pixel mode the odd bus is held at zero.
// - In one-pixel mode every pixel goes out on the even bus, one per clock.
// - In two-pixel mode even pixels use the even bus, odd pixels the odd bus.
// - Each bus carries blue in bits 0-7, green 8-15, red 16-23.
// - Pixel bits change at the update edge of the generated output pixel clock; staggered odd bits change half a period later.
// - Channel 0 gives blue when active, horizontal and vertical sync in blanking.
// - Channel 1 gives green when active, control one in blanking.
// - Channel 2 gives red when active, controls two and three in blanking.
// - Link-active flag is high while data enable toggles, low once it has stood still for the idle timeout.
// - In two-pixel mode a low stagger select offsets odd from even output.
// - Select high means two pixels per clock; two-pixel mode starts each line with pixel zero.
// - Polarity high makes data valid at rising clock edge, low at falling.
//
// Decided for this implementation: the address map and strobed register access.
module tpo_pixel_output
	import tpo_pkg::*;
#(
	parameter int unsigned LINK_IDLE_CYC = LINK_IDLE_CYCLES
) (
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_b_in,
	input  wire logic                  link_clock_in,
	input  wire logic                  link_de_in,
	input  wire logic [COLOR_W-1:0]    link_channel_zero_in,
	input  wire logic                  link_hsync_in,
	input  wire logic                  link_vsync_in,
	input  wire logic [COLOR_W-1:0]    link_channel_one_in,
	input  wire logic                  link_ctl1_in,
	input  wire logic [COLOR_W-1:0]    link_channel_two_in,
	input  wire logic [1:0]            link_ctl23_in,
	input  wire logic                  pixels_per_clock_select_in,
	input  wire logic                  stagger_select_n_in,
	input  wire logic                  output_clock_polarity_select_in,
	input  wire logic [REG_ADDR_W-1:0] reg_addr_in,
	input  wire logic [REG_DATA_W-1:0] reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic [REG_DATA_W-1:0]      reg_rdata_out,
	output logic                       irq_out,
	output logic [PIX_W-1:0]           even_pixel_bus_out,
	output logic [PIX_W-1:0]           odd_pixel_bus_out,
	output logic                       output_pixel_clock_out,
	output logic                       de_out,
	output logic                       hsync_out,
	output logic                       vsync_out,
	output logic [2:0]                 ctl_out,
	output logic                       link_active_flag_out
);

	// The timeout must outlast the sampling of at least one data enable toggle.
	if (LINK_IDLE_CYC < 2) begin : g_bad_idle
		$error("LINK_IDLE_CYC must be at least 2");
	end

	typedef struct packed {
		logic                  clk_s1;
		logic                  clk_s2;
		logic                  clk_s3;
		logic [LW_W-1:0]       word_s1;
		logic [LW_W-1:0]       word_s2;
		logic [MODE_W-1:0]     mode_s1;
		logic [MODE_W-1:0]     mode_s2;
		tpo_phase_t            phase;
		logic                  prev_de;
		logic [PIX_W-1:0]      even_hold;
		logic [PIX_W-1:0]      odd_pend;
		logic                  odd_pending;
		logic [PIX_W-1:0]      even_bus;
		logic [PIX_W-1:0]      odd_bus;
		logic                  ock;
		logic                  de;
		logic                  hsync;
		logic                  vsync;
		logic [2:0]            ctl;
		logic                  prev_active;
		logic [IRQ_W-1:0]      irq_status;
		logic [IRQ_W-1:0]      irq_mask;
		logic [REG_DATA_W-1:0] rdata;
	} tpo_state_t;

	tpo_state_t q;
	tpo_state_t d;

	logic             link_rise;
	logic             link_fall;
	logic             two_pix;
	logic             stagger_select_n_n;
	logic             pol;
	logic             cur_de;
	logic [PIX_W-1:0] pix_w;
	logic             active_w;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	// Pixel assembled from the three channel bytes; forced to zero during blanking.
	function automatic logic [PIX_W-1:0] pixel_of(input logic [LW_W-1:0] w);
		logic [PIX_W-1:0] p;
		p = '0;
		if (w[LW_DE]) begin
			p[BLUE_LSB +: COLOR_W]  = w[LW_CH0_LSB +: COLOR_W];
			p[GREEN_LSB +: COLOR_W] = w[LW_CH1_LSB +: COLOR_W];
			p[RED_LSB +: COLOR_W]   = w[LW_CH2_LSB +: COLOR_W];
		end
		return p;
	endfunction : pixel_of

	// Blanking controls in output order: bit 0 control one, bits 1 and 2 controls two and three.
	function automatic logic [2:0] ctl_of(input logic [LW_W-1:0] w);
		return {w[LW_CTL23_LSB +: 2], w[LW_CTL1]};
	endfunction : ctl_of

	assign link_rise = q.clk_s2 && !q.clk_s3;
	assign link_fall = !q.clk_s2 && q.clk_s3;
	assign two_pix   = q.mode_s2[MODE_TWO];
	assign stagger_select_n_n    = q.mode_s2[MODE_STAGGER_SELECT_N_N];
	assign pol       = q.mode_s2[MODE_POL];
	assign cur_de    = q.word_s2[LW_DE];
	assign pix_w     = pixel_of(q.word_s2);

	tpo_activity_monitor #(
		.IDLE_CYCLES (LINK_IDLE_CYC)
	) u_monitor (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.de_in      (cur_de),
		.active_out (active_w)
	);

	always_comb begin
		d = q;
		irq_set = '0;
		irq_clr = '0;
		// Every link input passes two flops before anything reads it.
		d.clk_s1  = link_clock_in;
		d.clk_s2  = q.clk_s1;
		d.clk_s3  = q.clk_s2;
		d.word_s1 = {link_de_in, link_vsync_in, link_hsync_in, link_ctl1_in, link_ctl23_in,
			link_channel_two_in, link_channel_one_in, link_channel_zero_in};
		d.word_s2 = q.word_s1;
		// Mode pins are levels; a change takes effect at the next link rise or link fall, so possibly mid pixel.
		d.mode_s1 = {output_clock_polarity_select_in, stagger_select_n_in,
			pixels_per_clock_select_in};
		d.mode_s2 = q.mode_s1;

		if (link_rise) begin
			d.prev_de = cur_de;
			if (!two_pix) begin
				// The output clock runs at the link rate; stagger is ignored here.
				d.even_bus    = pix_w;
				d.odd_bus     = '0;
				d.odd_pending = 1'b0;
				d.phase       = PH_FIRST;
				d.ock         = !pol;
				d.de          = cur_de;
				d.hsync       = q.word_s2[LW_HSYNC];
				d.vsync       = q.word_s2[LW_VSYNC];
				d.ctl         = ctl_of(q.word_s2);
			end else if (q.phase == PH_FIRST || (cur_de && !q.prev_de)) begin
				// A fresh line always starts with even pixel zero.
				d.even_hold = pix_w;
				d.phase     = PH_SECOND;
				d.ock       = pol;
				if (q.odd_pending) begin
					d.odd_bus     = q.odd_pend;
					d.odd_pending = 1'b0;
				end
			end else begin
				d.even_bus = q.even_hold;
				if (!stagger_select_n_n) begin
					// Odd output waits for the mid-period point to spread switching current.
					d.odd_pend    = pix_w;
					d.odd_pending = 1'b1;
				end else begin
					d.odd_bus = pix_w;
				end
				d.phase = PH_FIRST;
				d.ock   = !pol;
				d.de    = cur_de;
				d.hsync = q.word_s2[LW_HSYNC];
				d.vsync = q.word_s2[LW_VSYNC];
				d.ctl   = ctl_of(q.word_s2);
			end
		end else if (link_fall && !two_pix) begin
			d.ock = pol;
		end

		// Events and register port.
		d.prev_active = active_w;
		irq_set[IRQ_LINK_UP]   = active_w && !q.prev_active;
		irq_set[IRQ_LINK_DOWN] = !active_w && q.prev_active;
		irq_set[IRQ_FRAME]     = d.vsync && !q.vsync;
		d.rdata = '0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				REG_IRQ_STATUS: begin
					d.rdata[IRQ_W-1:0] = q.irq_status;
					irq_clr = q.irq_status;
				end
				REG_IRQ_MASK: begin
					d.rdata[IRQ_W-1:0] = q.irq_mask;
				end
				REG_STATUS: begin
					d.rdata[3:0] = {pol, stagger_select_n_n, two_pix, active_w};
				end
				default: begin
					d.rdata = '0;
				end
			endcase
		end
		if (reg_wr_in && reg_addr_in == REG_IRQ_MASK) begin
			d.irq_mask = reg_wdata_in[IRQ_W-1:0];
		end
		// A new event in the clearing read's cycle stays set.
		d.irq_status = (q.irq_status & ~irq_clr) | irq_set;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			q            <= '0;
			q.irq_mask   <= IRQ_MASK_RST;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata_out          = q.rdata;
	assign irq_out                = |(q.irq_status & q.irq_mask);
	assign even_pixel_bus_out     = q.even_bus;
	assign odd_pixel_bus_out      = q.odd_bus;
	assign output_pixel_clock_out = q.ock;
	assign de_out                 = q.de;
	assign hsync_out              = q.hsync;
	assign vsync_out              = q.vsync;
	assign ctl_out                = q.ctl;
	assign link_active_flag_out   = active_w;

	default clocking px_cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);

	AST_ODD_ZERO_ONE_PIX: assert property ((link_rise && !two_pix) |=> odd_pixel_bus_out == '0)
		else $error("Odd bus not zero in one-pixel mode.");
	AST_EVEN_EACH_PIXEL: assert property (
		(link_rise && !two_pix) |=> even_pixel_bus_out == $past(pix_w))
		else $error("Even bus missed a pixel in one-pixel mode.");
	AST_PAIR_SAME_CYCLE: assert property (
		(link_rise && two_pix && stagger_select_n_n && q.phase == PH_SECOND && !(cur_de && !q.prev_de))
		|=> even_pixel_bus_out == $past(q.even_hold) && odd_pixel_bus_out == $past(pix_w))
		else $error("Pixel pair not presented together.");
	AST_COLOR_LANES: assert property ((link_rise && !two_pix && cur_de) |=>
		even_pixel_bus_out[BLUE_LSB +: COLOR_W] == $past(q.word_s2[LW_CH0_LSB +: COLOR_W])
		&& even_pixel_bus_out[RED_LSB +: COLOR_W] == $past(q.word_s2[LW_CH2_LSB +: COLOR_W]))
		else $error("Colour bytes on wrong lanes.");
	AST_BLANK_CONTROLS: assert property ((link_rise && !two_pix && !cur_de) |=>
		even_pixel_bus_out == '0 && hsync_out == $past(q.word_s2[LW_HSYNC])
		&& ctl_out == $past({q.word_s2[LW_CTL23_LSB +: 2], q.word_s2[LW_CTL1]}))
		else $error("Blanking controls not taken from the channels.");
	AST_STAGGER_HOLDS_ODD: assert property (
		(link_rise && two_pix && !stagger_select_n_n && q.phase == PH_SECOND && !(cur_de && !q.prev_de))
		|=> $stable(odd_pixel_bus_out) && q.odd_pending)
		else $error("Odd bus moved with even bus while staggered.");
	AST_CLOCK_IDLE_AT_UPDATE: assert property ((link_rise && !two_pix) |=>
		output_pixel_clock_out == !$past(pol))
		else $error("Output clock at wrong level when data changed.");
	AST_CLOCK_EDGE_MID: assert property ((link_fall && !two_pix) |=>
		output_pixel_clock_out == $past(pol) && $stable(even_pixel_bus_out))
		else $error("Latching edge missing or data moved at it.");

	// Two-pixel mode: the first rise of a pair holds the even pixel and gives the latching edge.
	AST_TWO_PIX_STORE: assert property (
		(link_rise && two_pix && (q.phase == PH_FIRST || (cur_de && !q.prev_de)))
		|=> q.phase == PH_SECOND && q.even_hold == $past(pix_w) && $stable(even_pixel_bus_out))
		else $error("First pixel of a pair not held back as the even pixel.");
	AST_TWO_PIX_LATCH_EDGE: assert property (
		(link_rise && two_pix && (q.phase == PH_FIRST || (cur_de && !q.prev_de)))
		|=> output_pixel_clock_out == $past(pol))
		else $error("Latching edge missing between two-pixel updates.");
	AST_TWO_PIX_UPDATE_EDGE: assert property (
		(link_rise && two_pix && q.phase == PH_SECOND && !(cur_de && !q.prev_de))
		|=> output_pixel_clock_out == !$past(pol) && even_pixel_bus_out == $past(q.even_hold))
		else $error("Two-pixel update not aligned with the output clock.");
	AST_STAGGER_RELEASE: assert property (
		(link_rise && two_pix && q.odd_pending
		&& (q.phase == PH_FIRST || (cur_de && !q.prev_de)))
		|=> odd_pixel_bus_out == $past(q.odd_pend) && !q.odd_pending)
		else $error("Staggered odd pixel not released half an output period later.");

	// Register port and interrupt events.
	AST_READ_DATA_ONE_CYCLE: assert property (!reg_rd_in |=> reg_rdata_out == '0)
		else $error("Read data stood beyond its one cycle.");
	AST_EVENT_SET_WINS: assert property ((irq_set != '0) |=>
		(q.irq_status & $past(irq_set)) == $past(irq_set))
		else $error("Interrupt event lost to a clearing read.");

	COV_ONE_PIX: cover property (link_rise && !two_pix && cur_de);
	COV_TWO_PIX: cover property (link_rise && two_pix && stagger_select_n_n && q.phase == PH_SECOND);
	COV_STAGGER: cover property (link_rise && q.odd_pending);
	COV_LINK_DOWN: cover property (irq_set[IRQ_LINK_DOWN]);
	COV_FRESH_LINE: cover property (link_rise && two_pix && cur_de && !q.prev_de);

endmodule : tpo_pixel_output

/* File: design/tpo_pkg.sv */
// Shared constants and types for the TMDS receiver pixel output stage.
package tpo_pkg;

	// Pixel layout on each 24-bit bus.
	localparam int unsigned PIX_W        = 24;
	localparam int unsigned COLOR_W      = 8;
	localparam int unsigned BLUE_LSB     = 0;
	localparam int unsigned GREEN_LSB    = 8;
	localparam int unsigned RED_LSB      = 16;

	// Layout of the synchronised link word: three channel bytes, controls, data enable.
	localparam int unsigned LW_CH0_LSB   = 0;
	localparam int unsigned LW_CH1_LSB   = 8;
	localparam int unsigned LW_CH2_LSB   = 16;
	localparam int unsigned LW_CTL23_LSB = 24;
	localparam int unsigned LW_CTL1      = 26;
	localparam int unsigned LW_HSYNC     = 27;
	localparam int unsigned LW_VSYNC     = 28;
	localparam int unsigned LW_DE        = 29;
	localparam int unsigned LW_W         = 30;

	// Synchronised mode pins.
	localparam int unsigned MODE_TWO     = 0;
	localparam int unsigned MODE_STAGGER_SELECT_N_N  = 1;
	localparam int unsigned MODE_POL     = 2;
	localparam int unsigned MODE_W       = 3;

	// Timing of the link activity monitor.
	localparam int unsigned SYS_CLK_KHZ       = 10_000;
	localparam int unsigned LINK_IDLE_TIME_US = 1_000;
	localparam int unsigned LINK_IDLE_CYCLES  = LINK_IDLE_TIME_US * SYS_CLK_KHZ / 1_000;

	// Register port.
	localparam int unsigned REG_ADDR_W     = 4;
	localparam int unsigned REG_DATA_W     = 32;
	localparam logic [3:0]  REG_IRQ_STATUS = 4'h0;
	localparam logic [3:0]  REG_IRQ_MASK   = 4'h4;
	localparam logic [3:0]  REG_STATUS     = 4'h8;

	// Interrupt bits, shared by status and mask.
	localparam int unsigned IRQ_W          = 3;
	localparam int unsigned IRQ_LINK_UP    = 0;
	localparam int unsigned IRQ_LINK_DOWN  = 1;
	localparam int unsigned IRQ_FRAME      = 2;
	localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

	typedef enum logic {
		PH_FIRST,
		PH_SECOND
	} tpo_phase_t;

endpackage : tpo_pkg

/* File: design/tpo_activity_monitor.sv */
// Link activity monitor: watches data enable toggling and raises an activity flag.
module tpo_activity_monitor
	import tpo_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = LINK_IDLE_CYCLES
) (
	input  wire logic clk_sys_in,
	input  wire logic rst_b_in,
	input  wire logic de_in,
	output logic      active_out
);

	localparam int unsigned CNT_W = $clog2(IDLE_CYCLES + 1);

	if (IDLE_CYCLES < 2) begin : g_bad_idle
		$error("IDLE_CYCLES must be at least 2");
	end

	typedef struct packed {
		logic             prev_de;
		logic [CNT_W-1:0] count;
		logic             active;
	} tpo_mon_t;

	tpo_mon_t q;
	tpo_mon_t d;

	always_comb begin
		d = q;
		d.prev_de = de_in;
		if (de_in != q.prev_de) begin
			d.count  = '0;
			d.active = 1'b1;
		end else if (q.count == CNT_W'(IDLE_CYCLES)) begin
			d.active = 1'b0;
		end else begin
			d.count = q.count + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign active_out = q.active;

	default clocking mon_cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);

	AST_TOGGLE_SETS_ACTIVE: assert property ((de_in != q.prev_de) |=> active_out)
		else $error("Data enable toggled but link activity stayed low.");
	AST_IDLE_CLEARS_ACTIVE: assert property (
		(q.count == CNT_W'(IDLE_CYCLES) && de_in == q.prev_de) |=> !active_out)
		else $error("Data enable stood still past the timeout but activity stayed high.");

endmodule : tpo_activity_monitor

/* File: tb/tpo_panel_model.sv */
// Panel-side model that latches active pixels on the selected output clock edge.
module tpo_panel_model
	import tpo_pkg::*;
(
	input  wire logic             clk_out_in,
	input  wire logic             pol_in,
	input  wire logic             drive_on_in,
	input  wire logic             de_in,
	input  wire logic [PIX_W-1:0] even_in,
	input  wire logic [PIX_W-1:0] odd_in
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [PIX_W-1:0] even_q[$];
	logic [PIX_W-1:0] odd_q[$];

	// The activity flag gates the drivers, so nothing is seen while the link is idle.
	always @(clk_out_in) begin
		if (clk_out_in === pol_in && drive_on_in === 1'b1 && de_in === 1'b1) begin
			even_q.push_back(even_in);
			odd_q.push_back(odd_in);
		end
	end
endmodule : tpo_panel_model

/* File: tb/tpo_pixel_output_bench.sv */
// Self-checking bench for the pixel output stage.
module tpo_pixel_output_bench;
	import tpo_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned IDLE = 200;
	logic             clk, rst_b, lclk, de, hs, vs, c1, two, sn, pol, wr, rd;
	logic [1:0]       c23;
	logic [7:0]       ch0, ch1, ch2;
	logic [3:0]       addr;
	logic [31:0]      wdata, rdata, v;
	logic             irq, oclk, de_o, hs_o, vs_o, act;
	logic [2:0]       ctl;
	logic [PIX_W-1:0] ev, od;
	int               fail_count, compares;

	tpo_pixel_output #(.LINK_IDLE_CYC(IDLE)) i_tpo_pixel_output (
		.clk_sys_in(clk), .rst_b_in(rst_b), .link_clock_in(lclk), .link_de_in(de),
		.link_channel_zero_in(ch0), .link_hsync_in(hs), .link_vsync_in(vs),
		.link_channel_one_in(ch1), .link_ctl1_in(c1), .link_channel_two_in(ch2),
		.link_ctl23_in(c23), .pixels_per_clock_select_in(two), .stagger_select_n_in(sn),
		.output_clock_polarity_select_in(pol), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
		.even_pixel_bus_out(ev), .odd_pixel_bus_out(od), .output_pixel_clock_out(oclk),
		.de_out(de_o), .hsync_out(hs_o), .vsync_out(vs_o), .ctl_out(ctl),
		.link_active_flag_out(act)
	);

	tpo_panel_model i_tpo_panel_model (
		.clk_out_in(oclk), .pol_in(pol), .drive_on_in(act), .de_in(de_o),
		.even_in(ev), .odd_in(od)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// The recovered pixel clock runs free at an unrelated phase.
	initial begin
		lclk = 1'b0;
		#37;
		forever #400 lclk = ~lclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic stop_test;
		if (fail_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		repeat (2) @(negedge clk);
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : reg_rd

	// Link data change just after a falling link edge, well clear of the sampling edge.
	task automatic put(input logic d, input logic [23:0] p, input logic [4:0] k);
		@(negedge lclk);
		@(posedge clk);
		de                <= d;
		{ch2, ch1, ch0}   <= p;
		{vs, hs, c23, c1} <= k;
	endtask : put

	task automatic t_one(input logic p);
		logic [23:0] px[4] = '{24'h0102f0, 24'hff0080, 24'h5a3c0f, 24'h00a501};
		@(posedge clk);
		pol <= p;
		two <= 1'b0;
		sn  <= 1'b0;
		repeat (3) put(1'b0, 24'h0, 5'h0);
		i_tpo_panel_model.even_q.delete();
		i_tpo_panel_model.odd_q.delete();
		foreach (px[i]) put(1'b1, px[i], 5'h0);
		repeat (2) put(1'b0, 24'h0, 5'h0);
		chk(i_tpo_panel_model.even_q.size(), 4);
		foreach (px[i]) begin
			chk(i_tpo_panel_model.even_q[i], px[i]);
			chk(i_tpo_panel_model.odd_q[i], 24'h0);
		end
	endtask : t_one

	task automatic t_regs;
		@(negedge clk);
		chk(irq, 1'b1);
		reg_rd(REG_IRQ_STATUS);
		chk(v, 32'h1);
		reg_rd(REG_IRQ_STATUS);
		chk(irq, 1'b0);
		chk(v, 32'h0);
		reg_wr(REG_STATUS, 32'hf);
		reg_rd(REG_STATUS);
		chk(v, 32'h1);
		reg_rd(4'hc);
		chk(v, 32'h0);
	endtask : t_regs

	task automatic t_blank;
		logic [4:0] k[2] = '{5'h1b, 5'h0c};
		logic [4:0] e[2] = '{5'h1b, 5'h0c};
		foreach (k[i]) begin
			put(1'b0, 24'h123456, k[i]);
			@(posedge lclk);
			repeat (6) @(posedge clk);
			@(negedge clk);
			chk({vs_o, hs_o, ctl}, e[i]);
			chk({de_o, ev}, 25'h0);
		end
		put(1'b0, 24'h0, 5'h0);
	endtask : t_blank

	task automatic t_two(input logic s);
		int te, to;
		two <= 1'b1;
		sn  <= s;
		pol <= 1'b1;
		repeat (3) put(1'b0, 24'h0, 5'h0);
		put(1'b1, 24'hc1c2c3, 5'h0);
		put(1'b1, 24'hd4d5d6, 5'h0);
		te = -1;
		to = -1;
		for (int n = 0; n < 40; n++) begin
			@(negedge clk);
			if (te < 0 && ev === 24'hc1c2c3) te = n;
			if (to < 0 && od === 24'hd4d5d6) to = n;
		end
		chk(te >= 0, 1'b1);
		chk(to - te, s ? 0 : 8);
		put(1'b0, 24'h0, 5'h0);
	endtask : t_two

	task automatic t_idle;
		repeat (IDLE + 20) @(posedge clk);
		@(negedge clk);
		chk({act, irq}, 2'b01);
		reg_wr(REG_IRQ_MASK, 32'h0);
		chk(irq, 1'b0);
		reg_wr(REG_IRQ_MASK, 32'h3);
		chk(irq, 1'b1);
		reg_rd(REG_IRQ_STATUS);
		chk(v, 32'h6);
		@(negedge clk);
		chk(irq, 1'b0);
	endtask : t_idle

	initial begin
		{rst_b, de, hs, vs, c1, two, pol, wr, rd, c23} = '0;
		{ch0, ch1, ch2, addr, wdata} = '0;
		sn = 1'b1;
		fail_count = 0;
		compares = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		reg_wr(REG_IRQ_MASK, 32'h3);
		t_one(1'b1);
		t_one(1'b0);
		t_regs();
		t_blank();
		t_two(1'b1);
		t_two(1'b0);
		t_idle();
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end
endmodule : tpo_pixel_output_bench
